// [rtl/rvi_top.sv]
// rgb video input port: avalon registers, ram address counter, frame timing
`timescale 1ns/1ps
`include "rvi_defs.svh"
module rvi_top
	import rvi_pkg::*;
#(
	parameter int RAM_WORDS = `RVI_RAM_WORDS
)
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// rgb pins
	input  wire logic        frame_sync,
	input  wire logic        line_sync,
	input  wire logic        data_enable,
	input  wire logic        pixel_clock,
	input  wire logic [17:0] pixel_data_lines,
	// display ram write port
	output logic             ram_we,
	output logic [16:0]      ram_addr,
	output logic [17:0]      ram_wdata,
	// panel timing
	output logic             panel_dot_tick,
	output logic             panel_line_tick,
	output logic             panel_frame_tick,
	output logic             partial_scroll_allow
);
	initial
	begin
		if (RAM_WORDS < 1 || RAM_WORDS > 131072)
			$error("RAM_WORDS out of range");
	end

	localparam logic [16:0] LAST_ADDR = 17'(RAM_WORDS - 1);

	// register state
	logic [31:0] ctrl_ff;
	logic [16:0] start_ff;
	logic [7:0]  index_ff;
	logic [8:0]  lines_ff;
	logic        rd_done_ff;

	// datapath state
	logic [16:0] addr_ff;
	rvi_frame_t  frame_ff;
	logic [8:0]  line_cnt_ff;

	// decoded control
	logic        rgb_mode;
	logic        ram_access_source_select;
	logic [1:0]  rgb_bus_width_select;
	logic        line_buffered_write_mode;
	logic [3:0]  pol;
	logic        rgb_path_open;

	// events and pixels
	rvi_pix_if   ev ();
	logic        pix_valid;
	logic [17:0] pix_data;
	rvi_sub_t    sub_state;
	logic        pix_write;

	// bus decode
	logic        wr_ctrl, wr_start, wr_index, wr_sysdata, wr_lines;
	logic        sys_stall;
	logic        sys_ram_write;

	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[b*8 +: 8] = new_v[b*8 +: 8];
		return r;
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	assign rgb_mode                 = ctrl_ff[`RVI_CTRL_RGB_EN];
	assign ram_access_source_select = ctrl_ff[`RVI_CTRL_SRC];
	assign rgb_bus_width_select     = ctrl_ff[`RVI_CTRL_WID_LO +: 2];
	assign line_buffered_write_mode = ctrl_ff[`RVI_CTRL_HWM];
	assign pol                      = ctrl_ff[`RVI_CTRL_PCLK_POL +: 4];

	// rgb writes go only while the ram belongs to the pixel port and index points at ram data
	assign rgb_path_open = rgb_mode && ram_access_source_select
		&& index_ff == `RVI_IDX_RAM_WRITE && frame_ff != RVI_ST_FRONT;

	rvi_pin_sync u_sync
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.pin_vsync  (frame_sync),
		.pin_hsync  (line_sync),
		.pin_enable (data_enable),
		.pin_pclk   (pixel_clock),
		.pin_data   (pixel_data_lines),
		.pol        (pol),
		.ev         (ev)
	);

	rvi_pix_asm u_asm
	(
		.clk       (clk),
		.rst_n     (rst_n),
		.enable    (rgb_path_open),
		.width     (rgb_bus_width_select),
		.ev        (ev),
		.pix_valid (pix_valid),
		.pix_data  (pix_data),
		.sub_state (sub_state)
	);

	// register writes come only over this bus; the pixel port never reaches them
	assign wr_ctrl    = avs_write && hit(avs_address, `RVI_REG_CTRL);
	assign wr_start   = avs_write && hit(avs_address, `RVI_REG_START);
	assign wr_index   = avs_write && hit(avs_address, `RVI_REG_INDEX);
	assign wr_lines   = avs_write && hit(avs_address, `RVI_REG_LINES);
	assign wr_sysdata = avs_write && hit(avs_address, `RVI_REG_SYSDATA);

	// a pixel write owns the ram port this cycle; a system write waits one cycle
	assign pix_write     = pix_valid && rgb_path_open;
	assign sys_stall     = wr_sysdata && pix_write;
	assign sys_ram_write = wr_sysdata && !sys_stall && !ram_access_source_select
		&& index_ff == `RVI_IDX_RAM_WRITE;

	assign avs_waitrequest = (avs_read && !rd_done_ff) || sys_stall;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			ctrl_ff <= `RVI_CTRL_RST;
		else if (wr_ctrl)
			ctrl_ff <= be_merge(ctrl_ff, avs_writedata, avs_byteenable) & 32'h0000_0f1f;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			start_ff <= '0;
		else if (wr_start)
			start_ff <= 17'(be_merge({15'h0000, start_ff}, avs_writedata, avs_byteenable));
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			index_ff <= '0;
		else if (wr_index && avs_byteenable[0])
			index_ff <= avs_writedata[7:0];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			lines_ff <= `RVI_LINES_RST;
		else if (wr_lines)
			lines_ff <= 9'(be_merge({23'h000000, lines_ff}, avs_writedata, avs_byteenable));
	end

	// reads take one wait cycle so read data always comes from a flop
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rd_done_ff   <= 1'b0;
			avs_readdata <= '0;
		end
		else if (avs_read && !rd_done_ff)
		begin
			rd_done_ff <= 1'b1;
			case (avs_address)
				`RVI_REG_CTRL:    avs_readdata <= ctrl_ff;
				`RVI_REG_START:   avs_readdata <= {15'h0000, start_ff};
				`RVI_REG_INDEX:   avs_readdata <= {24'h000000, index_ff};
				`RVI_REG_LINES:   avs_readdata <= {23'h000000, lines_ff};
				`RVI_REG_STATUS:  avs_readdata <= {8'h00, sub_state, frame_ff, line_buffered_write_mode,
					addr_ff, 2'h0};
				default:          avs_readdata <= '0;
			endcase
		end
		else
			rd_done_ff <= 1'b0;
	end

	// frame sequencing runs off the sampled pixel-port syncs, not an internal oscillator
	always_ff @(posedge clk)
	begin
		if (!rst_n || !rgb_mode)
		begin
			frame_ff    <= RVI_ST_FRONT;
			line_cnt_ff <= '0;
		end
		else if (ev.vs_fall)
		begin
			frame_ff    <= RVI_ST_BACK;
			line_cnt_ff <= '0;
		end
		else
		begin
			case (frame_ff)
				RVI_ST_FRONT:
					frame_ff <= RVI_ST_FRONT;
				RVI_ST_BACK:
					if (ev.de_active && ev.pclk_edge)
						frame_ff <= RVI_ST_ACTIVE;
				RVI_ST_ACTIVE:
					if (ev.hs_fall)
					begin
						if (line_cnt_ff + 9'h001 >= lines_ff)
							frame_ff <= RVI_ST_FRONT;
						line_cnt_ff <= line_cnt_ff + 9'h001;
					end
				default:
					frame_ff <= RVI_ST_FRONT;
			endcase
		end
	end

	// address counter: reload on frame start, advance per written pixel, wrap at end of ram
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			addr_ff <= '0;
		else if (wr_start)
			addr_ff <= 17'(be_merge({15'h0000, start_ff}, avs_writedata, avs_byteenable));
		else if (rgb_mode && ev.vs_fall)
			addr_ff <= start_ff;
		else if (pix_write || sys_ram_write)
			addr_ff <= (addr_ff == LAST_ADDR) ? 17'h00000 : addr_ff + 17'h00001;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ram_we    <= 1'b0;
			ram_addr  <= '0;
			ram_wdata <= '0;
		end
		else
		begin
			ram_we <= pix_write || sys_ram_write;
			if (pix_write)
			begin
				ram_addr  <= addr_ff;
				ram_wdata <= pix_data;
			end
			else if (sys_ram_write)
			begin
				ram_addr  <= addr_ff;
				ram_wdata <= avs_writedata[17:0];
			end
		end
	end

	// panel ticks follow the pixel clock, line sync and frame sync while rgb mode is on
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			panel_dot_tick       <= 1'b0;
			panel_line_tick      <= 1'b0;
			panel_frame_tick     <= 1'b0;
			partial_scroll_allow <= 1'b1;
		end
		else
		begin
			panel_dot_tick       <= rgb_mode && ev.pclk_edge;
			panel_line_tick      <= rgb_mode && ev.hs_fall;
			panel_frame_tick     <= rgb_mode && ev.vs_fall;
			partial_scroll_allow <= !rgb_mode;
		end
	end
endmodule

// [rtl/rvi_defs.svh]
// constants for the rgb video input port: offsets, fields, resets, counts
// Function
// - enable low: capture data, write display ram
// - width 10: 6-bit mode, upper lines
// - 6-bit: three transfers make one pixel
// - component counter cleared on frame-sync fall
// - width 01: 16-bit, one pixel per clock
// - width 00: 18-bit, one pixel per clock
// - registers written only through system bus
// - no partial display or scroll in rgb
// - panel timing from pixel clock in rgb
// - front porch holds until next frame sync
// - frame-sync fall reloads ram address counter
// - four polarity bits invert sync/enable/clock
`ifndef RVI_DEFS_SVH
`define RVI_DEFS_SVH
`define RVI_REG_CTRL       8'h00
`define RVI_REG_START      8'h04
`define RVI_REG_INDEX      8'h08
`define RVI_REG_SYSDATA    8'h0c
`define RVI_REG_LINES      8'h10
`define RVI_REG_STATUS     8'h14
`define RVI_CTRL_RGB_EN    0
`define RVI_CTRL_SRC       1
`define RVI_CTRL_WID_LO    2
`define RVI_CTRL_HWM       4
`define RVI_CTRL_PCLK_POL  8
`define RVI_CTRL_DE_POL    9
`define RVI_CTRL_HS_POL    10
`define RVI_CTRL_VS_POL    11
`define RVI_CTRL_RST       32'h0000_0000
`define RVI_WID_18         2'h0
`define RVI_WID_16         2'h1
`define RVI_WID_6          2'h2
`define RVI_IDX_RAM_WRITE  8'h22
`define RVI_LINES_RST      9'h1b0
`define RVI_RAM_WORDS      103680
`endif

// [rtl/rvi_pkg.sv]
// types shared by the rgb video input port
package rvi_pkg;
	typedef enum logic [1:0] {RVI_ST_FRONT, RVI_ST_BACK, RVI_ST_ACTIVE} rvi_frame_t;
	typedef enum logic [1:0] {RVI_SP_RED, RVI_SP_GREEN, RVI_SP_BLUE} rvi_sub_t;
endpackage

// [rtl/rvi_pix_if.sv]
// synchronised pin events passed from the pin sampler to the assembler and top
`timescale 1ns/1ps
interface rvi_pix_if;
	logic        pclk_edge;
	logic        vs_fall;
	logic        hs_fall;
	logic        de_active;
	logic [17:0] data;
	modport src (output pclk_edge, output vs_fall, output hs_fall, output de_active, output data);
	modport dst (input pclk_edge, input vs_fall, input hs_fall, input de_active, input data);
endinterface

// [rtl/rvi_pin_sync.sv]
// three-flop sampling of the rgb pins with polarity and edge detection
`timescale 1ns/1ps
module rvi_pin_sync
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// raw pins
	input  wire logic        pin_vsync,
	input  wire logic        pin_hsync,
	input  wire logic        pin_enable,
	input  wire logic        pin_pclk,
	input  wire logic [17:0] pin_data,
	// polarity: pclk, enable, hsync, vsync
	input  wire logic [3:0]  pol,
	// events
	rvi_pix_if.src           ev
);
	logic [21:0] s1_ff, s2_ff, s3_ff;
	logic [3:0]  lvl_ff;
	logic [3:0]  agree;
	logic [3:0]  norm;
	// sampler keeps running in reset so the flops hold real pin levels at release
	always_ff @(posedge clk)
	begin
		s1_ff <= {pin_vsync, pin_hsync, pin_enable, pin_pclk, pin_data};
		s2_ff <= s1_ff;
		s3_ff <= s2_ff;
	end
	// polarity bit set inverts the pin so that logic always sees active-low syncs
	assign norm  = s2_ff[21:18] ^ pol;
	assign agree = ~(s2_ff[21:18] ^ s3_ff[21:18]);
	always_ff @(posedge clk)
	begin
		// level tracks the pins in reset; a fixed value would fake a sync edge at release
		if (!rst_n)
			lvl_ff <= norm;
		else
		begin
			for (int i = 0; i < 4; i++)
				if (agree[i])
					lvl_ff[i] <= norm[i];
		end
	end
	// pclk bit 0, enable bit 1, hsync bit 2, vsync bit 3
	assign ev.pclk_edge = agree[0] & norm[0] & ~lvl_ff[0];
	assign ev.de_active = ~lvl_ff[1];
	assign ev.hs_fall   = agree[2] & ~norm[2] & lvl_ff[2];
	assign ev.vs_fall   = agree[3] & ~norm[3] & lvl_ff[3];
	assign ev.data      = s3_ff[17:0];
endmodule

// [rtl/rvi_pix_asm.sv]
// pixel assembly for 18-, 16- and 6-bit bus widths
`timescale 1ns/1ps
module rvi_pix_asm
	import rvi_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        enable,
	input  wire logic [1:0]  width,
	// events
	rvi_pix_if.dst           ev,
	// assembled pixel
	output logic             pix_valid,
	output logic [17:0]      pix_data,
	output rvi_sub_t         sub_state
);
	rvi_sub_t    sub_ff;
	logic [11:0] rg_ff;
	logic        take;
	assign take      = enable & ev.pclk_edge & ev.de_active;
	assign sub_state = sub_ff;
	always_ff @(posedge clk)
	begin
		if (!rst_n || ev.vs_fall || width != `RVI_WID_6)
			sub_ff <= RVI_SP_RED;
		else if (take)
		begin
			case (sub_ff)
				RVI_SP_RED:   sub_ff <= RVI_SP_GREEN;
				RVI_SP_GREEN: sub_ff <= RVI_SP_BLUE;
				default:      sub_ff <= RVI_SP_RED;
			endcase
		end
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rg_ff <= '0;
		else if (take && sub_ff == RVI_SP_RED)
			rg_ff[11:6] <= ev.data[17:12];
		else if (take && sub_ff == RVI_SP_GREEN)
			rg_ff[5:0] <= ev.data[17:12];
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pix_valid <= 1'b0;
			pix_data  <= '0;
		end
		else
		begin
			pix_valid <= 1'b0;
			if (take)
			begin
				case (width)
					`RVI_WID_18:
					begin
						pix_valid <= 1'b1;
						pix_data  <= ev.data;
					end
					`RVI_WID_16:
					begin
						pix_valid <= 1'b1;
						pix_data  <= {ev.data[17:13], ev.data[17], ev.data[11:6], ev.data[5:1], ev.data[5]};
					end
					`RVI_WID_6:
					begin
						pix_valid <= (sub_ff == RVI_SP_BLUE);
						pix_data  <= {rg_ff, ev.data[17:12]};
					end
					default:
						pix_valid <= 1'b0;
				endcase
			end
		end
	end
endmodule

// [verif/rvi_top_assertions.sv]
// concurrent checks on the rgb video input port top ports
`timescale 1ns/1ps
module rvi_top_assertions
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// register bus
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	// rgb pins
	input wire logic        frame_sync,
	input wire logic        line_sync,
	input wire logic        pixel_clock,
	// ram port and panel timing
	input wire logic        ram_we,
	input wire logic [16:0] ram_addr,
	input wire logic [17:0] ram_wdata,
	input wire logic        panel_dot_tick,
	input wire logic        panel_line_tick,
	input wire logic        panel_frame_tick,
	input wire logic        partial_scroll_allow
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// cycles since a cause; saturates so an idle pin never looks fresh
	logic [3:0] pc_ff, ls_ff, fs_ff, sw_ff;
	logic [2:0] pin_ff;
	function automatic logic [3:0] age(input logic hit, input logic [3:0] a);
		return hit ? 4'h0 : (a == 4'hf) ? a : a + 4'h1;
	endfunction
	always_ff @(posedge clk)
	begin
		pin_ff <= {pixel_clock, line_sync, frame_sync};
	end
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pc_ff <= 4'hf;
			ls_ff <= 4'hf;
			fs_ff <= 4'hf;
			sw_ff <= 4'hf;
		end
		else
		begin
			pc_ff <= age(pixel_clock != pin_ff[2], pc_ff);
			ls_ff <= age(line_sync != pin_ff[1], ls_ff);
			fs_ff <= age(frame_sync != pin_ff[0], fs_ff);
			sw_ff <= age(avs_write && avs_address == 8'h0c, sw_ff);
		end
	end
	a_read_one_wait:
		assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("read wait");
	a_write_no_wait:
		assert property (avs_write && avs_address != 8'h0c |-> !avs_waitrequest) else $error("write wait");
	a_dot_tick_cause:
		assert property (panel_dot_tick |-> pc_ff <= 4'h8) else $error("dot tick");
	a_line_tick_cause:
		assert property (panel_line_tick |-> ls_ff <= 4'h8) else $error("line tick");
	a_frame_tick_cause:
		assert property (panel_frame_tick |-> fs_ff <= 4'h8) else $error("frame tick");
	a_ticks_rgb_only:
		assert property (partial_scroll_allow |-> !(panel_dot_tick || panel_line_tick || panel_frame_tick))
		else $error("tick outside rgb");
	a_we_has_cause:
		assert property (ram_we |-> pc_ff <= 4'h8 || sw_ff <= 4'h3) else $error("write cause");
	a_we_data_hold:
		assert property (!ram_we |-> $stable(ram_addr) && $stable(ram_wdata)) else $error("ram hold");
endmodule

// [verif/rvi_video_src.sv]
// behavioural video source driving the rgb pins
`timescale 1ns/1ps
module rvi_video_src
(
	// clock
	input  wire logic   clk,
	// rgb pins
	output logic        frame_sync,
	output logic        line_sync,
	output logic        data_enable,
	output logic        pixel_clock,
	output logic [17:0] pixel_data_lines
);
	initial
	begin
		frame_sync = 1'b1;
		line_sync = 1'b1;
		data_enable = 1'b1;
		pixel_clock = 1'b0;
		pixel_data_lines = 18'h0;
	end
	// frame-sync pulse held low for 8 clocks, then 8 idle clocks
	task automatic frame();
		frame_sync <= 1'b0;
		repeat (8) @(posedge clk);
		frame_sync <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	task automatic line();
		line_sync <= 1'b0;
		repeat (8) @(posedge clk);
		line_sync <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
	// clock stands still between dots; data lines then show the inverse
	task automatic dot(input logic [17:0] d, input logic de);
		pixel_data_lines <= d;
		data_enable <= de;
		repeat (4) @(posedge clk);
		pixel_clock <= 1'b1;
		repeat (4) @(posedge clk);
		pixel_clock <= 1'b0;
		data_enable <= 1'b1;
		pixel_data_lines <= ~d;
	endtask
endmodule

// [verif/test_rgb_video_input_port.sv]
// self-checking bench for the rgb video input port
`timescale 1ns/1ps
`include "rvi_defs.svh"
module test_rgb_video_input_port;
	logic        clk, rst_n, avs_read, avs_write, avs_waitrequest, scroll_ok;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rv;
	logic        frame_sync, line_sync, data_enable, pixel_clock, ram_we;
	logic [17:0] pixel_data_lines, ram_wdata;
	logic [16:0] ram_addr;
	logic [31:0] qa[$], qd[$];
	int          err_count, total_checks, cycles;
	rvi_top uut
	(
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .frame_sync(frame_sync), .line_sync(line_sync),
		.data_enable(data_enable), .pixel_clock(pixel_clock), .pixel_data_lines(pixel_data_lines),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .panel_dot_tick(),
		.panel_line_tick(), .panel_frame_tick(), .partial_scroll_allow(scroll_ok)
	);
	rvi_video_src src
	(
		.clk(clk), .frame_sync(frame_sync), .line_sync(line_sync), .data_enable(data_enable),
		.pixel_clock(pixel_clock), .pixel_data_lines(pixel_data_lines)
	);
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic complete_run();
		if (err_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (ram_we === 1'b1)
		begin
			qa.push_back(32'(ram_addr));
			qd.push_back(32'(ram_wdata));
		end
		if (cycles == 5000)
		begin
			err_count++;
			complete_run();
		end
	end
	// idle edge after release so back-to-back calls never re-drive in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rv = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), rv, e);
	endtask
	task automatic px(input logic [17:0] d, input logic de);
		src.dot(d, de);
		repeat (4) @(posedge clk);
	endtask
	task automatic got(input logic [31:0] n, input logic [31:0] a, input logic [31:0] d);
		chk("ram write count", 32'(qa.size()), n);
		if (n != 0 && qa.size() != 0)
		begin
			chk("ram_addr", qa.pop_front(), a);
			chk("ram_wdata", qd.pop_front(), d);
		end
	endtask
	task automatic ctl(input logic [1:0] w, input logic s, input logic [3:0] p);
		bus(1'b1, `RVI_REG_CTRL, {20'h0, p, 3'h0, 1'b1, w, s, 1'b1});
	endtask
	initial
	begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h0;
		avs_writedata = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(`RVI_REG_CTRL, 32'h0);
		rdc(`RVI_REG_LINES, 32'h1b0);
		rdc(8'h20, 32'h0);
		chk("partial_scroll_allow", 32'(scroll_ok), 32'h1);
		bus(1'b1, `RVI_REG_START, 32'h10);
		bus(1'b1, `RVI_REG_INDEX, 32'h22);
		bus(1'b1, `RVI_REG_LINES, 32'h1);
		ctl(`RVI_WID_18, 1'b1, 4'h0);
		src.frame();
		chk("partial_scroll_allow", 32'(scroll_ok), 32'h0);
		px(18'h2a5c3, 1'b0);
		got(1, 32'h10, 32'h2a5c3);
		px(18'h1ffff, 1'b1);
		got(0, 0, 0);
		src.line();
		px(18'h00abc, 1'b0);
		got(0, 0, 0);
		ctl(`RVI_WID_16, 1'b1, 4'h0);
		src.frame();
		px(18'h3c0f5, 1'b0);
		got(1, 32'h10, 32'h3d0f5);
		ctl(`RVI_WID_6, 1'b1, 4'h0);
		src.frame();
		px({6'h15, 12'hfff}, 1'b0);
		src.frame();
		px({6'h21, 12'hfff}, 1'b0);
		px({6'h0c, 12'h000}, 1'b0);
		got(0, 0, 0);
		px({6'h3f, 12'hfff}, 1'b0);
		got(1, 32'h10, 32'h2133f);
		ctl(`RVI_WID_6, 1'b0, 4'h0);
		bus(1'b1, `RVI_REG_SYSDATA, 32'h0abcd);
		repeat (4) @(posedge clk);
		got(1, 32'h11, 32'h0abcd);
		ctl(`RVI_WID_18, 1'b1, 4'h2);
		bus(1'b1, `RVI_REG_INDEX, 32'h22);
		bus(1'b1, `RVI_REG_SYSDATA, 32'h01234);
		repeat (4) @(posedge clk);
		got(0, 0, 0);
		src.frame();
		px(18'h2aaaa, 1'b0);
		got(0, 0, 0);
		px(18'h155aa, 1'b1);
		got(1, 32'h10, 32'h155aa);
		complete_run();
	end
endmodule
bind rvi_top rvi_top_assertions chk_i
(
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .frame_sync(frame_sync), .line_sync(line_sync),
	.pixel_clock(pixel_clock), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
	.panel_dot_tick(panel_dot_tick), .panel_line_tick(panel_line_tick),
	.panel_frame_tick(panel_frame_tick), .partial_scroll_allow(partial_scroll_allow)
);
